// file: hw/spc_pkg.sv
/*
  Package for the serial port: register layout, reset values, modes
  and timing constants. Assumes a 100 MHz system clock on sys_clk.
*/
package spc_pkg;
  // ============================================================
  // Register map
  localparam logic [1:0] SPC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] SPC_ADDR_BUF = 2'h1;
  localparam logic [1:0] SPC_ADDR_CFG = 2'h2;
  localparam logic [7:0] SPC_CTRL_RESET = 8'h00;
  localparam logic [7:0] SPC_CFG_RESET = 8'h00;
  // ============================================================
  // Control field positions
  localparam int SPC_BIT_MODE_HI = 7;
  localparam int SPC_BIT_MODE_LO = 6;
  localparam int SPC_BIT_FILTER = 5;
  localparam int SPC_BIT_RX_ALLOW = 4;
  localparam int SPC_BIT_TX9 = 3;
  localparam int SPC_BIT_RX9 = 2;
  localparam int SPC_BIT_TX_DONE = 1;
  localparam int SPC_BIT_RX_DONE = 0;
  // Config register: bit0 six-clock operation, bit1 baud_doubler
  localparam int SPC_BIT_SIXCLK = 0;
  localparam int SPC_BIT_DOUBLER = 1;
  // ============================================================
  // Modes and sequencer states
  typedef enum logic [1:0] {
    SPC_MODE_SHIFT = 2'b00,
    SPC_MODE_UART8 = 2'b01,
    SPC_MODE_UART9F = 2'b10,
    SPC_MODE_UART9V = 2'b11
  } spc_mode_t;
  typedef enum logic [1:0] {
    SPC_IDLE = 2'b00,
    SPC_TX = 2'b01,
    SPC_RX_ARM = 2'b10,
    SPC_RX = 2'b11
  } spc_state_t;
  // ============================================================
  // Timing: oscillator phase period, phases per machine cycle
  localparam int SPC_OSC_NS = 20;
  localparam int SPC_SYS_NS = 10;
  localparam logic [3:0] SPC_OSC_DIV = 4'(SPC_OSC_NS / SPC_SYS_NS);
  localparam logic [3:0] SPC_PHASES_12 = 4'hc;
  localparam logic [3:0] SPC_PHASES_6 = 4'h6;
  localparam logic [3:0] SPC_BITS = 4'h8;
  localparam logic [3:0] SPC_OVERSAMPLE = 4'hf;
  localparam logic [8:0] SPC_RX_FILL = 9'h1fe;
  localparam logic [5:0] SPC_M2_DIV_HI = 6'h3f;
  localparam logic [5:0] SPC_M2_DIV_LO = 6'h1f;
  localparam logic [7:0] SPC_VAR_RELOAD = 8'h00;
endpackage

// file: hw/spc_timing.sv
/*
  Machine-cycle timing generator: one-cycle pulses marking the state
  and phase points used by the serial port. Same clock as the port.
*/
`timescale 1ns/100ps
module spc_timing
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic six_clock,
  output logic s1p1,
  output logic s3p1,
  output logic s5p2,
  output logic s6p1,
  output logic s6p2,
  output logic clk_low_window
);
  import spc_pkg::*;
  logic [3:0] osc_cnt;
  logic [3:0] phase;
  logic osc_tick;
  logic [3:0] last_phase;
  // ============================================================
  // Oscillator tick and phase counter
  assign osc_tick = (osc_cnt == SPC_OSC_DIV - 4'h1);
  assign last_phase = six_clock ? SPC_PHASES_6 - 4'h1
                                : SPC_PHASES_12 - 4'h1;
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      osc_cnt <= 4'h0;
    else if (osc_tick)
      osc_cnt <= 4'h0;
    else
      osc_cnt <= osc_cnt + 4'h1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      phase <= 4'h0;
    else if (osc_tick)
      phase <= (phase >= last_phase) ? 4'h0 : phase + 4'h1;
  end
  // ============================================================
  // Phase decode: 12-clock counts phases, 6-clock counts states
  always_comb
  begin
    if (six_clock)
    begin
      s1p1 = osc_tick && phase == 4'h0;
      s3p1 = osc_tick && phase == 4'h2;
      s5p2 = osc_tick && phase == 4'h4;
      s6p1 = osc_tick && phase == 4'h5;
      s6p2 = osc_tick && phase == 4'h5;
      clk_low_window = phase >= 4'h2 && phase <= 4'h4;
    end
    else
    begin
      s1p1 = osc_tick && phase == 4'h0;
      s3p1 = osc_tick && phase == 4'h4;
      s5p2 = osc_tick && phase == 4'h9;
      s6p1 = osc_tick && phase == 4'ha;
      s6p2 = osc_tick && phase == 4'hb;
      clk_low_window = phase >= 4'h4 && phase <= 4'h9;
    end
  end
endmodule // spc_timing

// file: hw/spc_serial_port.sv
/*
  Serial port: control/status register, buffer, shift-register mode
  and UART modes 1 to 3. Assumes a CPU-side register port on sys_clk
  and serial pins from outside the clock domain.
*/
// Local design decisions: strobed register access and the register offsets.
// Behaviour
// R1: Eight-bit control register, mode bits high to done flags low, reset zero.
// R2: Mode bits: 00 shift, 01 8-bit variable, 10 9-bit fixed, 11 9-bit variable.
// R3: In 9-bit modes with filter set, ninth bit zero suppresses rx done.
// R4: In 8-bit mode with filter set, rx done needs a valid stop bit.
// R5: Software keeps the filter bit clear in shift mode.
// R6: Ninth bit store: 9-bit data, 8-bit stop bit, unused in shift mode.
// R7: Tx done set at end of bit eight or stop start; software clears.
// R8: Rx done set mid stop bit in UART modes; software clears.
// R9: Ninth tx bit sent in 9-bit modes; receive only while allowed.
// R10: Shift mode moves eight bits LSB first on data pin, clock driven.
// R11: Shift bit rate is oscillator over twelve, or six in 6-clock.
// R12: Buffer write starts shift transmit and loads marker one at S6P2.
// R13: One machine cycle passes from buffer write to tx active.
// R14: Tx active routes shift data to port3_bit0 and clock to port3_bit1.
// R15: Tx shift clock low in S3 to S5, high in S6, S1, S2.
// R16: At S6P2 with tx active, shift tx register right filling zeros.
// R17: Marker beside MSB: last shift, drop tx active, set tx done at S1P1.
// R18: Receive starts when allowed and rx done clear; load 11111110.
// R19: Rx active drives shift clock toggling at S3P1 and S6P1.
// R20: At S6P2 with rx active, shift the receive register once.
// R21: Receive shift is left, taking the S5P2 sample of port3_bit0.
// R22: Zero at left: last shift, load buffer, drop rx active, set rx done.
`timescale 1ns/100ps
module spc_serial_port
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic port3_bit0_in,
  output logic port3_bit0_out,
  output logic port3_bit0_oe,
  output logic port3_bit1_out,
  output logic tx_active_strobe,
  output logic rx_active_strobe
);
  import spc_pkg::*;
  logic [7:0] serial_ctrl_status;
  logic [7:0] cfg;
  logic [7:0] rx_buffer;
  logic [1:0] rxd_sync;
  logic rxd;
  logic s1p1, s3p1, s5p2, s6p1, s6p2, clk_low;
  spc_mode_t mode;
  spc_state_t state;
  logic [9:0] tx_sr;
  logic [8:0] rx_sr;
  logic tx_pend;
  logic tx_armed;
  logic [7:0] rx_rev;
  logic [7:0] m2_base;
  logic [7:0] m2_reload;
  logic uart_rx_start;
  logic [3:0] rx_sub;
  logic [3:0] rx_bits;
  logic sample;
  logic shift_clk;
  logic set_tx_done, set_rx_done, load_rx9, rx9_val;
  logic wr_ctrl, wr_buf;
  logic [5:0] div_cnt;
  logic [7:0] var_cnt;
  logic bit16_tick;
  logic [3:0] sub_cnt;
  logic [3:0] bit_cnt;
  logic uart_tx_busy, uart_rx_busy;
  logic [2:0] votes;
  logic rxd_prev;

  assign mode = spc_mode_t'(serial_ctrl_status[7:6]); // R2
  assign wr_ctrl = reg_wr && reg_addr == SPC_ADDR_CTRL;
  assign wr_buf = reg_wr && reg_addr == SPC_ADDR_BUF;

  // ============================================================
  // Pin synchroniser
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rxd_sync <= 2'b11;
    else
      rxd_sync <= {rxd_sync[0], port3_bit0_in};
  end
  assign rxd = rxd_sync[1];

  spc_timing u_timing
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .six_clock(cfg[SPC_BIT_SIXCLK]), // R11
    .s1p1(s1p1),
    .s3p1(s3p1),
    .s5p2(s5p2),
    .s6p1(s6p1),
    .s6p2(s6p2),
    .clk_low_window(clk_low)
  );

  // ============================================================
  // Control register with set-wins flags
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      serial_ctrl_status <= SPC_CTRL_RESET; // R1
    else
    begin
      if (wr_ctrl)
        serial_ctrl_status <= reg_wdata;
      if (load_rx9)
        serial_ctrl_status[SPC_BIT_RX9] <= rx9_val; // R6
      if (set_tx_done)
        serial_ctrl_status[SPC_BIT_TX_DONE] <= 1'b1; // R7
      if (set_rx_done)
        serial_ctrl_status[SPC_BIT_RX_DONE] <= 1'b1; // R8
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      cfg <= SPC_CFG_RESET;
    else if (reg_wr && reg_addr == SPC_ADDR_CFG)
      cfg <= reg_wdata;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        SPC_ADDR_CTRL: reg_rdata <= serial_ctrl_status;
        SPC_ADDR_BUF: reg_rdata <= rx_buffer;
        SPC_ADDR_CFG: reg_rdata <= cfg;
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ============================================================
  // UART bit-rate: x16 tick, mode 2 fixed, modes 1/3 variable
  assign m2_base = {2'b00, cfg[SPC_BIT_DOUBLER] ? SPC_M2_DIV_LO
                                                : SPC_M2_DIV_HI} + 8'h01;
  assign m2_reload = ((m2_base * {4'h0, SPC_OSC_DIV})
    >> (4 + cfg[SPC_BIT_SIXCLK])) - 8'h01;
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      div_cnt <= 6'h00;
    else
      div_cnt <= (div_cnt == 6'h00) ? m2_reload[5:0] : div_cnt - 6'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      var_cnt <= SPC_VAR_RELOAD;
    else if (s1p1)
      var_cnt <= (var_cnt == 8'h00) ? SPC_VAR_RELOAD : var_cnt - 8'h01;
  end
  assign bit16_tick = (mode == SPC_MODE_UART9F) ? div_cnt == 6'h00
                                                : s1p1 && var_cnt == 8'h00;

  // ============================================================
  // Main sequencer
  assign set_tx_done = (state == SPC_TX && s1p1 && tx_sr == 10'h001)
    || (uart_tx_busy && bit16_tick && sub_cnt == SPC_OVERSAMPLE
        && bit_cnt == ((mode == SPC_MODE_UART8) ? 4'h8 : 4'h9)); // R17 R7
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      state <= SPC_IDLE;
      tx_sr <= 10'h3ff;
      tx_pend <= 1'b0;
      tx_armed <= 1'b0;
    end
    else
    begin
      case (state)
        SPC_IDLE:
        begin
          if (mode == SPC_MODE_SHIFT && wr_buf)
          begin
            tx_sr <= {2'b01, reg_wdata}; // R12
            tx_pend <= 1'b1;
            tx_armed <= 1'b0;
          end
          else if (mode == SPC_MODE_SHIFT && tx_pend && s6p2)
          begin
            if (tx_armed)
            begin
              tx_pend <= 1'b0;
              tx_armed <= 1'b0;
              state <= SPC_TX; // R13
            end
            else
              tx_armed <= 1'b1; // R13
          end
          else if (mode == SPC_MODE_SHIFT && !tx_pend
                   && serial_ctrl_status[SPC_BIT_RX_ALLOW]
                   && !serial_ctrl_status[SPC_BIT_RX_DONE] && s1p1)
            state <= SPC_RX_ARM; // R18
        end
        SPC_TX:
        begin
          if (s6p2)
            tx_sr <= {1'b0, tx_sr[9:1]}; // R16
          if (s1p1 && tx_sr == 10'h001)
            state <= SPC_IDLE; // R17
        end
        SPC_RX_ARM:
          if (s6p2)
            state <= SPC_RX; // R18
        SPC_RX:
          if (s1p1 && rx_sr[8] == 1'b0)
            state <= SPC_IDLE; // R22
        default: state <= SPC_IDLE;
      endcase
    end
  end
  assign tx_active_strobe = state == SPC_TX;
  assign rx_active_strobe = state == SPC_RX;

  // ============================================================
  // Shift-mode receive path
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      sample <= 1'b1;
    else if (s5p2)
      sample <= rxd; // R21
  end
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rx_sr <= SPC_RX_FILL;
    else if (state == SPC_RX_ARM && s6p2)
      rx_sr <= SPC_RX_FILL; // R18
    else if (state == SPC_RX && s6p2 && rx_sr[8])
      rx_sr <= {rx_sr[7:0], sample}; // R20 R21
    else if (uart_rx_start)
      rx_sr <= 9'h1ff;
    else if (uart_rx_busy && bit16_tick && rx_sub == 4'h9)
      rx_sr <= {votes[0] & votes[1] | votes[2] & votes[0]
                | votes[1] & votes[2], rx_sr[8:1]};
  end
  for (genvar g = 0; g < 8; g++)
  begin : g_rev
    assign rx_rev[g] = rx_sr[7 - g]; // R10
  end

  // ============================================================
  // Shift clock generation
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      shift_clk <= 1'b1;
    else if (state == SPC_RX && (s3p1 || s6p1))
      shift_clk <= ~shift_clk; // R19
    else if (state != SPC_RX)
      shift_clk <= 1'b1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      port3_bit0_out <= 1'b1;
      port3_bit0_oe <= 1'b0;
      port3_bit1_out <= 1'b1;
    end
    else
    begin
      port3_bit0_out <= (state == SPC_TX) ? tx_sr[0] : 1'b1; // R14 R10
      port3_bit0_oe <= state == SPC_TX; // R10
      if (state == SPC_TX)
        port3_bit1_out <= ~clk_low; // R15
      else if (state == SPC_RX)
        port3_bit1_out <= shift_clk; // R19
      else if (mode != SPC_MODE_SHIFT)
        port3_bit1_out <= uart_frame[0];
      else
        port3_bit1_out <= 1'b1;
    end
  end

  // ============================================================
  // UART modes: transmit on port3_bit1, receive on port3_bit0
  logic [10:0] uart_frame;
  assign uart_rx_start = !uart_rx_busy && mode != SPC_MODE_SHIFT
    && serial_ctrl_status[SPC_BIT_RX_ALLOW] && rxd_prev && !rxd; // R9
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      uart_tx_busy <= 1'b0;
      sub_cnt <= 4'h0;
      bit_cnt <= 4'h0;
    end
    else if (mode != SPC_MODE_SHIFT && wr_buf && !uart_tx_busy)
    begin
      uart_tx_busy <= 1'b1;
      sub_cnt <= 4'h0;
      bit_cnt <= 4'h0;
    end
    else if (uart_tx_busy && bit16_tick)
    begin
      sub_cnt <= sub_cnt + 4'h1;
      if (sub_cnt == SPC_OVERSAMPLE)
      begin
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == ((mode == SPC_MODE_UART8) ? 4'h9 : 4'ha))
          uart_tx_busy <= 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      uart_frame <= 11'h7ff;
    else if (mode != SPC_MODE_SHIFT && wr_buf && !uart_tx_busy)
      uart_frame <= (mode == SPC_MODE_UART8)
        ? {2'b11, reg_wdata, 1'b0}
        : {1'b1, serial_ctrl_status[SPC_BIT_TX9], reg_wdata, 1'b0}; // R9
    else if (uart_tx_busy && bit16_tick && sub_cnt == SPC_OVERSAMPLE)
      uart_frame <= {1'b1, uart_frame[10:1]};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      uart_rx_busy <= 1'b0;
      rx_sub <= 4'h0;
      rx_bits <= 4'h0;
      votes <= 3'b111;
      rxd_prev <= 1'b1;
    end
    else
    begin
      rxd_prev <= rxd;
      if (!uart_rx_busy)
      begin
        if (mode != SPC_MODE_SHIFT && serial_ctrl_status[SPC_BIT_RX_ALLOW]
            && rxd_prev && !rxd) // R9
        begin
          uart_rx_busy <= 1'b1;
          rx_sub <= 4'h0;
          rx_bits <= 4'h0;
        end
      end
      else if (bit16_tick)
      begin
        rx_sub <= rx_sub + 4'h1;
        if (rx_sub >= 4'h6 && rx_sub <= 4'h8)
          votes <= {votes[1:0], rxd};
        if (rx_sub == 4'h9 && rx_bits == 4'h0 && votes[1] && votes[0])
          uart_rx_busy <= 1'b0;
        if (rx_sub == SPC_OVERSAMPLE)
          rx_bits <= rx_bits + 4'h1;
        if (rx_sub == 4'h9 && rx_bits ==
            ((mode == SPC_MODE_UART8) ? 4'h9 : 4'ha))
          uart_rx_busy <= 1'b0;
      end
    end
  end
  logic uart_last, uart_stop, uart_ok;
  assign uart_last = uart_rx_busy && bit16_tick && rx_sub == 4'h9
    && rx_bits == ((mode == SPC_MODE_UART8) ? 4'h9 : 4'ha); // R8
  assign uart_stop = votes[0] & votes[1] | votes[2] & votes[0]
    | votes[1] & votes[2];
  assign uart_ok = !serial_ctrl_status[SPC_BIT_RX_DONE]
    && (!serial_ctrl_status[SPC_BIT_FILTER]
        || ((mode == SPC_MODE_UART8) ? uart_stop : rx_sr[8])); // R3 R4

  assign set_rx_done = (state == SPC_RX && s1p1 && rx_sr[8] == 1'b0)
    || (uart_last && uart_ok); // R22 R8
  assign load_rx9 = uart_last && uart_ok;
  assign rx9_val = (mode == SPC_MODE_UART8) ? uart_stop : rx_sr[8]; // R6

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      rx_buffer <= 8'h00;
    else if (state == SPC_RX && s1p1 && rx_sr[8] == 1'b0)
      rx_buffer <= rx_rev; // R22
    else if (load_rx9)
      rx_buffer <= (mode == SPC_MODE_UART8) ? rx_sr[8:1] : rx_sr[7:0];
  end
endmodule // spc_serial_port

// file: bench/spc_serial_port_assertions.sv
/*
  Checker for the serial port top ports.
  Assumes one sys_clk domain and the bind below.
*/
`timescale 1ns/100ps
module spc_serial_port_assertions
  import spc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic port3_bit0_out,
  input wire logic port3_bit0_oe,
  input wire logic port3_bit1_out,
  input wire logic tx_active_strobe,
  input wire logic rx_active_strobe
);
  // ============================================================
  // Helpers
  logic shift_mode;
  logic clk_q;
  logic [3:0] n_fall;
  wire active = tx_active_strobe | rx_active_strobe;
  always_ff @(posedge sys_clk)
    if (!resetn)
      shift_mode <= 1'b1;
    else if (reg_wr && reg_addr == SPC_ADDR_CTRL)
      shift_mode <= reg_wdata[7:6] == 2'b00;
  always_ff @(posedge sys_clk)
    if (!resetn || !active)
      n_fall <= 4'h0;
    else if (clk_q && !port3_bit1_out)
      n_fall <= n_fall + 4'h1;
  always_ff @(posedge sys_clk)
    clk_q <= port3_bit1_out;
  // ============================================================
  // Assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  AST_TX_START: assert property (reg_wr && reg_addr == SPC_ADDR_BUF
    && shift_mode && !active |-> ##[14:49] $rose(tx_active_strobe))
    else $error("shift transmit start out of window");
  AST_OE_TX: assert property (tx_active_strobe && $past(tx_active_strobe)
    |-> port3_bit0_oe) else $error("data pin not driven in transmit");
  AST_NO_OE_RX: assert property (rx_active_strobe |-> !port3_bit0_oe)
    else $error("data pin driven in receive");
  AST_EIGHT_CLK: assert property ($fell(active) |-> n_fall == 4'h8)
    else $error("shift clock count not eight");
  AST_CLK_LOW: assert property ($fell(port3_bit1_out) && active
    |-> !port3_bit1_out [*6]) else $error("shift clock low too short");
  AST_CLK_HIGH: assert property ($rose(port3_bit1_out) && active
    |-> port3_bit1_out [*6]) else $error("shift clock high too short");
  AST_DATA_HOLD: assert property (tx_active_strobe && !port3_bit1_out
    |-> $stable(port3_bit0_out)) else $error("data moved while clock low");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  COV_TX: cover property ($rose(tx_active_strobe));
  COV_RX: cover property ($rose(rx_active_strobe));
  COV_END: cover property ($fell(active));
endmodule // spc_serial_port_assertions

bind spc_serial_port spc_serial_port_assertions i_chk (.sys_clk(sys_clk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .port3_bit0_out(port3_bit0_out), .port3_bit0_oe(port3_bit0_oe),
  .port3_bit1_out(port3_bit1_out), .tx_active_strobe(tx_active_strobe),
  .rx_active_strobe(rx_active_strobe));

// file: bench/spc_shift_partner.sv
/*
  Shift-register peer for shift mode: captures sent bytes, returns a
  byte on receive. Assumes the port's shift clock and data pin.
*/
`timescale 1ns/100ps
module spc_shift_partner
(
  input wire logic shift_clk,
  input wire logic dev_oe,
  input wire logic dev_out,
  input wire logic dev_rx,
  input wire logic [7:0] send_byte,
  output wire logic pin,
  output logic [7:0] got_byte
);
  logic [7:0] sreg = 8'h00;
  logic drv = 1'b1;
  initial got_byte = 8'h00;
  assign pin = dev_oe ? dev_out : drv;
  // ============================================================
  // Capture on the falling shift clock while the port drives
  always @(negedge shift_clk)
    if (dev_oe)
      got_byte <= {dev_out, got_byte[7:1]};
  // ============================================================
  // Present LSB first, advance on the rising shift clock
  always @(posedge dev_rx)
  begin
    sreg = send_byte;
    drv = send_byte[0];
  end
  always @(posedge shift_clk)
    if (dev_rx)
    begin
      sreg = sreg >> 1;
      drv = sreg[0];
    end
  // Released line shows the inverse of its last value
  always @(negedge dev_rx)
    drv = ~drv;
endmodule // spc_shift_partner

// file: bench/spc_serial_port_tb.sv
/*
  Self-checking bench for the serial port: registers, shift mode both
  ways, mode 2 frames. Assumes 100 MHz sys_clk, 2 sys_clk per osc.
*/
`timescale 1ns/100ps
module spc_serial_port_tb;
  import spc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic uart_en = 1'b0;
  logic uart_rxd = 1'b1;
  logic [7:0] send_byte = 8'h00;
  logic [7:0] reg_rdata, got_byte, v, d;
  logic p0_out, p0_oe, p1_out, tx_act, rx_act;
  logic [10:0] frame;
  wire pin;
  int n_errors = 0;
  int checks_done = 0;
  int seed = 32'h9c8d;
  int i;
  always #5 sys_clk = ~sys_clk;
  spc_serial_port i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port3_bit0_in(uart_en ? uart_rxd : pin), .port3_bit0_out(p0_out),
    .port3_bit0_oe(p0_oe), .port3_bit1_out(p1_out),
    .tx_active_strobe(tx_act), .rx_active_strobe(rx_act));
  spc_shift_partner i_peer (.shift_clk(p1_out), .dev_oe(p0_oe),
    .dev_out(p0_out), .dev_rx(rx_act), .send_byte(send_byte), .pin(pin),
    .got_byte(got_byte));
  // ============================================================
  // Tasks
  task automatic results();
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask
  task automatic wait_ctrl(input int b);
    for (int k = 0; k < 3000; k++)
    begin
      rd(SPC_ADDR_CTRL, v);
      if (v[b] === 1'b1)
        return;
    end
    n_errors++;
    results();
  endtask
  task automatic cap_frame(output logic [10:0] f);
    int j;
    for (j = 0; j < 4000 && p1_out !== 1'b0; j++)
      @(negedge sys_clk);
    if (j == 4000)
    begin
      n_errors++;
      results();
    end
    repeat (64) @(negedge sys_clk);
    for (j = 0; j < 11; j++)
    begin
      f[j] = p1_out;
      repeat (128) @(negedge sys_clk);
    end
  endtask
  task automatic send_frame(input logic [10:0] f);
    for (int j = 0; j < 11; j++)
    begin
      @(posedge sys_clk);
      uart_rxd <= f[j];
      repeat (127) @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(SPC_ADDR_CTRL, v);
    chk(v, 8'h00);
    rd(2'h3, v);
    chk(v, 8'h00);
    wr(SPC_ADDR_CTRL, 8'hec);
    rd(SPC_ADDR_CTRL, v);
    chk(v, 8'hec);
    for (i = 0; i < 6; i++)
    begin
      d = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
      wr(SPC_ADDR_CFG, {7'h00, i[0]});
      wr(SPC_ADDR_CTRL, 8'h00);
      wr(SPC_ADDR_BUF, d);
      wait_ctrl(SPC_BIT_TX_DONE);
      chk(v, 8'h02);
      chk(got_byte, d);
    end
    for (i = 0; i < 4; i++)
    begin
      send_byte <= 8'($random(seed));
      wr(SPC_ADDR_CFG, {7'h00, i[0]});
      wr(SPC_ADDR_CTRL, 8'h10);
      wait_ctrl(SPC_BIT_RX_DONE);
      chk(v, 8'h11);
      rd(SPC_ADDR_BUF, v);
      chk(v, send_byte);
    end
    wr(SPC_ADDR_CFG, 8'h00);
    for (i = 0; i < 2; i++)
    begin
      d = 8'($random(seed));
      wr(SPC_ADDR_CTRL, {4'h8, i[0], 3'h0});
      wr(SPC_ADDR_BUF, d);
      cap_frame(frame);
      chk(frame, {1'b1, i[0], d, 1'b0});
      rd(SPC_ADDR_CTRL, v);
      chk(v, {4'h8, i[0], 3'h2});
    end
    uart_en <= 1'b1;
    for (i = 0; i < 3; i++)
    begin
      d = 8'($random(seed));
      wr(SPC_ADDR_CTRL, i == 1 ? 8'ha0 : 8'hb0);
      send_frame({1'b1, i != 0, d, 1'b0});
      rd(SPC_ADDR_CTRL, v);
      chk(v, i == 2 ? 8'hb5 : i == 1 ? 8'ha0 : 8'hb0);
    end
    rd(SPC_ADDR_BUF, v);
    chk(v, d);
    results();
  end
endmodule // spc_serial_port_tb
